// File: exc_consts.vh
// Summary of operation
// - take guest doorbell machine check only if unblocked, pending, enable and guest bits set
// - an accepted guest doorbell machine-check message raises the exception
// - machine check saves next instruction address and machine state in critical save registers
// - machine check keeps enable, debug and recoverable bits, clears all others
// - machine check vector is prefix high half, offset 39 middle bits, four zeros
// - guest doorbell critical and machine check share one vector offset register
// - guest supervisor use of hypervisor-only operations raises hypervisor trap
// - the explicit hypervisor-trap instruction always raises hypervisor trap
// - hypervisor trap saves faulting address and machine state in base save registers
// - hypervisor trap keeps check, critical, debug enables and recoverable bit
// - hypervisor trap vector is prefix high half, offset 41 middle bits, four zeros
// - guest supervisor traps listed instructions and listed special register accesses
// - guest supervisor return-from-interrupt is not trapped, runs as guest return
// - guest supervisor local TLB invalidate traps only when guest TLB disable is set
// - guest supervisor data fault address access goes to its guest copy
// - guest supervisor external proxy access goes to its guest copy
// - decrementer reload readable by hypervisor, trapped for guest supervisor
// - control register steers interrupts; guest supervisor access to it traps
// - only message types zero to four accepted; four is guest machine check
`ifndef EXC_CONSTS_VH
`define EXC_CONSTS_VH
// apb register byte offsets
`define OFS_MSW 8'h00
`define OFS_VPR 8'h04
`define OFS_VO39 8'h08
`define OFS_VO41 8'h0C
`define OFS_EPC 8'h10
`define OFS_CSPC 8'h14
`define OFS_CSST 8'h18
`define OFS_BSPC 8'h1C
`define OFS_BSST 8'h20
`define OFS_DFA 8'h24
`define OFS_GDFA 8'h28
`define OFS_EPV 8'h2C
`define OFS_GEPV 8'h30
`define OFS_DRV 8'h34
`define OFS_STAT 8'h38
// machine state and control register bit positions, bit 0 is least significant
`define MSW_GS 28
`define MSW_CE 17
`define MSW_PR 14
`define MSW_ME 12
`define MSW_DE 9
`define MSW_RI 1
`define EPC_GUEST_TLB_MGMT_DISABLE 22
// bits kept across each interrupt
`define KEEP_MC 32'h0000_1202
`define KEEP_HYP 32'h0002_1202
`define ZERO32 32'h0000_0000
// vector fields
`define VPR_HI 31
`define VPR_LO 16
`define VO_HI 15
`define VO_LO 4
`define VEC_PAD 4'h0
// doorbell messages
`define MSG_GDB_MC 5'h04
`define MSG_MAX 5'h04
// instruction codes on the execute port
`define OP_NONE 4'h0
`define OP_EHPRIV 4'h1
`define OP_MSGCLR 4'h2
`define OP_MSGSND 4'h3
`define OP_RFCI 4'h4
`define OP_RFDI 4'h5
`define OP_RFI 4'h6
`define OP_RFMCI 4'h7
`define OP_TLBILX 4'h8
`define OP_TLBIVAX 4'h9
`define OP_TLBRE 4'hA
`define OP_TLBSX 4'hB
`define OP_TLBSYNC 4'hC
`define OP_TLBWE 4'hD
// special register classes on the access port
`define SPR_OPEN 3'h0
`define SPR_PRIV 3'h1
`define SPR_DFA 3'h2
`define SPR_EPV 3'h3
`define SPR_DRV 3'h4
`define SPR_EPC 3'h5
`endif

// File: doorbell_hyp_exc.v
`timescale 1ns/1ns
`include "exc_consts.vh"
module doorbell_hyp_exc (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // doorbell messages from other cores
  input wire msg_valid,
  input wire [4:0] msg_type,
  // pipeline state
  input wire higher_pending,
  input wire [31:0] next_pc,
  // instruction execute port
  input wire insn_valid,
  input wire [3:0] insn_op,
  input wire [31:0] insn_pc,
  // special register access port
  input wire spr_req,
  input wire spr_wr,
  input wire [2:0] spr_sel,
  input wire [31:0] spr_wdata,
  output reg spr_rvalid,
  output reg [31:0] spr_rdata,
  // interrupt redirection
  output reg mc_taken,
  output reg hyp_taken,
  output reg rfi_as_guest,
  output reg [31:0] vector_addr
);

  reg [31:0] msw_q;
  reg [31:0] vpr_q;
  reg [31:0] vo39_q;
  reg [31:0] vo41_q;
  reg [31:0] epc_q;
  reg [31:0] cspc_q;
  reg [31:0] csst_q;
  reg [31:0] bspc_q;
  reg [31:0] bsst_q;
  reg [31:0] dfa_q;
  reg [31:0] gdfa_q;
  reg [31:0] epv_q;
  reg [31:0] gepv_q;
  reg [31:0] drv_q;
  reg pend_q;
  reg pend_d;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg insn_priv;
  reg insn_trap;
  reg spr_trap;
  reg [31:0] spr_mux;

  wire guest_sup;
  wire hyp_take;
  wire mc_take;
  wire msg_accept;
  wire apb_wr;
  wire apb_setup;
  wire spr_do_wr;
  wire apb_wr_msw;
  wire apb_wr_vpr;
  wire apb_wr_vo39;
  wire apb_wr_vo41;
  wire apb_wr_epc;
  wire apb_wr_cspc;
  wire apb_wr_csst;
  wire apb_wr_bspc;
  wire apb_wr_bsst;
  wire apb_wr_dfa;
  wire apb_wr_gdfa;
  wire apb_wr_epv;
  wire apb_wr_gepv;
  wire apb_wr_drv;
  wire spr_wr_dfa;
  wire spr_wr_gdfa;
  wire spr_wr_epv;
  wire spr_wr_gepv;
  wire spr_wr_drv;
  wire spr_wr_epc;

  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign guest_sup = msw_q[`MSW_GS] & ~msw_q[`MSW_PR];

  // only the five defined types are accepted; unknown types are dropped
  assign msg_accept = msg_valid & (msg_type <= `MSG_MAX);

  // instructions that only the hypervisor may run
  always @* begin
    case (insn_op)
      `OP_MSGCLR: insn_priv = 1'b1;
      `OP_MSGSND: insn_priv = 1'b1;
      `OP_RFCI: insn_priv = 1'b1;
      `OP_RFDI: insn_priv = 1'b1;
      `OP_RFMCI: insn_priv = 1'b1;
      `OP_TLBIVAX: insn_priv = 1'b1;
      `OP_TLBRE: insn_priv = 1'b1;
      `OP_TLBSX: insn_priv = 1'b1;
      `OP_TLBSYNC: insn_priv = 1'b1;
      `OP_TLBWE: insn_priv = 1'b1;
      `OP_TLBILX: insn_priv = epc_q[`EPC_GUEST_TLB_MGMT_DISABLE];
      `OP_RFI: insn_priv = 1'b0;
      default: insn_priv = 1'b0;
    endcase
  end

  always @* begin
    insn_trap = 1'b0;
    if (insn_valid) begin
      if (insn_op == `OP_EHPRIV) begin
        insn_trap = 1'b1;
      end else begin
        insn_trap = guest_sup & insn_priv;
      end
    end
  end

  always @* begin
    spr_trap = 1'b0;
    if (spr_req & guest_sup) begin
      case (spr_sel)
        `SPR_PRIV: spr_trap = 1'b1;
        `SPR_DRV: spr_trap = 1'b1;
        `SPR_EPC: spr_trap = 1'b1;
        default: spr_trap = 1'b0;
      endcase
    end
  end

  assign hyp_take = insn_trap | spr_trap;
  assign spr_do_wr = spr_req & spr_wr & ~spr_trap;

  // a synchronous trap of the current instruction is handled first
  assign mc_take = pend_q & msw_q[`MSW_ME] & msw_q[`MSW_GS] &
                   ~higher_pending & ~hyp_take;

  // new message wins over the clear of the same cycle
  always @* begin
    pend_d = pend_q;
    if (mc_take) begin
      pend_d = 1'b0;
    end
    if (msg_accept && (msg_type == `MSG_GDB_MC)) begin
      pend_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // guest copies are steered in by state, not by selector
  always @* begin
    case (spr_sel)
      `SPR_DFA: spr_mux = guest_sup ? gdfa_q : dfa_q;
      `SPR_EPV: spr_mux = guest_sup ? gepv_q : epv_q;
      `SPR_DRV: spr_mux = drv_q;
      `SPR_EPC: spr_mux = epc_q;
      default: spr_mux = `ZERO32;
    endcase
  end

  // apb read decode
  always @* begin
    rd_hit = 1'b1;
    case (paddr)
      `OFS_MSW: rd_mux = msw_q;
      `OFS_VPR: rd_mux = vpr_q;
      `OFS_VO39: rd_mux = vo39_q;
      `OFS_VO41: rd_mux = vo41_q;
      `OFS_EPC: rd_mux = epc_q;
      `OFS_CSPC: rd_mux = cspc_q;
      `OFS_CSST: rd_mux = csst_q;
      `OFS_BSPC: rd_mux = bspc_q;
      `OFS_BSST: rd_mux = bsst_q;
      `OFS_DFA: rd_mux = dfa_q;
      `OFS_GDFA: rd_mux = gdfa_q;
      `OFS_EPV: rd_mux = epv_q;
      `OFS_GEPV: rd_mux = gepv_q;
      `OFS_DRV: rd_mux = drv_q;
      `OFS_STAT: rd_mux = {31'h0000_0000, pend_q};
      default: begin
        rd_mux = `ZERO32;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read data is caught in the setup cycle so the access phase needs no wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ZERO32;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? `ZERO32 : rd_mux;
      pslverr <= ~rd_hit;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // apb write strobes; the status word and unmapped offsets take no write
  assign apb_wr_msw = apb_wr & (paddr == `OFS_MSW);
  assign apb_wr_vpr = apb_wr & (paddr == `OFS_VPR);
  assign apb_wr_vo39 = apb_wr & (paddr == `OFS_VO39);
  assign apb_wr_vo41 = apb_wr & (paddr == `OFS_VO41);
  assign apb_wr_epc = apb_wr & (paddr == `OFS_EPC);
  assign apb_wr_cspc = apb_wr & (paddr == `OFS_CSPC);
  assign apb_wr_csst = apb_wr & (paddr == `OFS_CSST);
  assign apb_wr_bspc = apb_wr & (paddr == `OFS_BSPC);
  assign apb_wr_bsst = apb_wr & (paddr == `OFS_BSST);
  assign apb_wr_dfa = apb_wr & (paddr == `OFS_DFA);
  assign apb_wr_gdfa = apb_wr & (paddr == `OFS_GDFA);
  assign apb_wr_epv = apb_wr & (paddr == `OFS_EPV);
  assign apb_wr_gepv = apb_wr & (paddr == `OFS_GEPV);
  assign apb_wr_drv = apb_wr & (paddr == `OFS_DRV);

  // core write strobes; a guest supervisor write lands in the guest copy
  assign spr_wr_dfa = spr_do_wr & (spr_sel == `SPR_DFA) & ~guest_sup;
  assign spr_wr_gdfa = spr_do_wr & (spr_sel == `SPR_DFA) & guest_sup;
  assign spr_wr_epv = spr_do_wr & (spr_sel == `SPR_EPV) & ~guest_sup;
  assign spr_wr_gepv = spr_do_wr & (spr_sel == `SPR_EPV) & guest_sup;
  assign spr_wr_drv = spr_do_wr & (spr_sel == `SPR_DRV);
  assign spr_wr_epc = spr_do_wr & (spr_sel == `SPR_EPC);

  // machine state; an exception save beats an apb write of the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msw_q <= `ZERO32;
    end else if (hyp_take) begin
      msw_q <= msw_q & `KEEP_HYP;
    end else if (mc_take) begin
      msw_q <= msw_q & `KEEP_MC;
    end else if (apb_wr_msw) begin
      msw_q <= pwdata;
    end
  end

  // vector base and offsets are written over apb only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpr_q <= `ZERO32;
      vo39_q <= `ZERO32;
      vo41_q <= `ZERO32;
    end else begin
      if (apb_wr_vpr) begin
        vpr_q <= pwdata;
      end
      if (apb_wr_vo39) begin
        vo39_q <= pwdata;
      end
      if (apb_wr_vo41) begin
        vo41_q <= pwdata;
      end
    end
  end

  // control register; a core write beats an apb write of the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epc_q <= `ZERO32;
    end else if (spr_wr_epc) begin
      epc_q <= spr_wdata;
    end else if (apb_wr_epc) begin
      epc_q <= pwdata;
    end
  end

  // critical save pair, loaded as the guest doorbell machine check is taken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cspc_q <= `ZERO32;
      csst_q <= `ZERO32;
    end else if (mc_take) begin
      cspc_q <= next_pc;
      csst_q <= msw_q;
    end else begin
      if (apb_wr_cspc) begin
        cspc_q <= pwdata;
      end
      if (apb_wr_csst) begin
        csst_q <= pwdata;
      end
    end
  end

  // base save pair; a trapped register access saves the pc of its instruction too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bspc_q <= `ZERO32;
      bsst_q <= `ZERO32;
    end else if (hyp_take) begin
      bspc_q <= insn_pc;
      bsst_q <= msw_q;
    end else begin
      if (apb_wr_bspc) begin
        bspc_q <= pwdata;
      end
      if (apb_wr_bsst) begin
        bsst_q <= pwdata;
      end
    end
  end

  // data fault address and its guest copy; apb reaches both by offset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dfa_q <= `ZERO32;
      gdfa_q <= `ZERO32;
    end else begin
      if (spr_wr_dfa) begin
        dfa_q <= spr_wdata;
      end else if (apb_wr_dfa) begin
        dfa_q <= pwdata;
      end
      if (spr_wr_gdfa) begin
        gdfa_q <= spr_wdata;
      end else if (apb_wr_gdfa) begin
        gdfa_q <= pwdata;
      end
    end
  end

  // external proxy value and its guest copy; apb reaches both by offset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epv_q <= `ZERO32;
      gepv_q <= `ZERO32;
    end else begin
      if (spr_wr_epv) begin
        epv_q <= spr_wdata;
      end else if (apb_wr_epv) begin
        epv_q <= pwdata;
      end
      if (spr_wr_gepv) begin
        gepv_q <= spr_wdata;
      end else if (apb_wr_gepv) begin
        gepv_q <= pwdata;
      end
    end
  end

  // decrementer reload; a trapped guest write never reaches it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_q <= `ZERO32;
    end else if (spr_wr_drv) begin
      drv_q <= spr_wdata;
    end else if (apb_wr_drv) begin
      drv_q <= pwdata;
    end
  end

  // redirection outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_taken <= 1'b0;
      hyp_taken <= 1'b0;
      rfi_as_guest <= 1'b0;
      vector_addr <= `ZERO32;
      spr_rvalid <= 1'b0;
      spr_rdata <= `ZERO32;
    end else begin
      mc_taken <= mc_take;
      hyp_taken <= hyp_take;
      rfi_as_guest <= insn_valid & guest_sup & (insn_op == `OP_RFI);
      if (hyp_take) begin
        vector_addr <= {vpr_q[`VPR_HI:`VPR_LO], vo41_q[`VO_HI:`VO_LO], `VEC_PAD};
      end else if (mc_take) begin
        // shared with the guest doorbell critical vector; handler checks saved state
        vector_addr <= {vpr_q[`VPR_HI:`VPR_LO], vo39_q[`VO_HI:`VO_LO], `VEC_PAD};
      end
      spr_rvalid <= spr_req & ~spr_wr & ~spr_trap;
      if (spr_req & ~spr_wr & ~spr_trap) begin
        spr_rdata <= spr_mux;
      end
    end
  end

endmodule // doorbell_hyp_exc

// File: doorbell_sender.sv
`timescale 1ns/1ns
module doorbell_sender (
  // clock
  input wire pclk,
  // message toward the core
  output logic msg_valid,
  output logic [4:0] msg_type
);
  initial begin
    msg_valid = 1'b0;
    msg_type = 5'h00;
  end
  // one message per call; the type field is inverted after release so stale data never matches
  task automatic send(input logic [4:0] t);
    msg_valid <= 1'b1;
    msg_type <= t;
    @(posedge pclk);
    msg_valid <= 1'b0;
    msg_type <= ~t;
  endtask
endmodule // doorbell_sender

// File: doorbell_hyp_exc_monitor.sv
`timescale 1ns/1ns
module doorbell_hyp_exc_monitor (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // inputs watched
  input wire higher_pending,
  input wire insn_valid,
  input wire [3:0] insn_op,
  input wire spr_req,
  input wire spr_wr,
  input wire [2:0] spr_sel,
  // outputs watched
  input wire spr_rvalid,
  input wire mc_taken,
  input wire hyp_taken,
  input wire rfi_as_guest,
  input wire [31:0] vector_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rfi;
    insn_valid && insn_op == 4'h6 && !spr_req;
  endsequence
  sequence s_redir_rd;
    spr_req && !spr_wr && spr_sel inside {3'h2, 3'h3} && !insn_valid;
  endsequence
  chk_ehpriv_trap: assert property (insn_valid && insn_op == 4'h1 |=> hyp_taken)
    else $error("trap instruction not trapped");
  chk_rfi_free: assert property (s_rfi |=> !hyp_taken)
    else $error("return trapped");
  chk_rfi_cause: assert property (rfi_as_guest |-> $past(insn_valid) && $past(insn_op) == 4'h6)
    else $error("guest return without cause");
  chk_vec_pad: assert property (hyp_taken || mc_taken |-> vector_addr[3:0] == 4'h0)
    else $error("vector low bits set");
  chk_mc_block: assert property (mc_taken |-> !$past(higher_pending) && !hyp_taken)
    else $error("machine check taken while blocked");
  chk_mc_once: assert property (mc_taken |=> !mc_taken)
    else $error("machine check taken twice");
  chk_redir_read: assert property (s_redir_rd |=> spr_rvalid)
    else $error("redirected read lost");
  chk_rvalid_cause: assert property (spr_rvalid |-> $past(spr_req) && !$past(spr_wr))
    else $error("read valid without read");
endmodule // doorbell_hyp_exc_monitor
bind doorbell_hyp_exc doorbell_hyp_exc_monitor u_mon (.*);

// File: tb_guest_doorbell_mc_and_hyp_privilege_trap.sv
`timescale 1ns/1ns
`include "exc_consts.vh"
module tb_guest_doorbell_mc_and_hyp_privilege_trap;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic higher_pending = 1'b0, insn_valid = 1'b0, spr_req = 1'b0, spr_wr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = '0, next_pc = '0, insn_pc = '0, spr_wdata = '0;
  logic [3:0] insn_op = 4'h0;
  logic [2:0] spr_sel = 3'h0;
  logic [4:0] msg_type;
  logic [31:0] prdata, spr_rdata, vector_addr, vpr, vo39, vo41, ms, rd, pc;
  logic pready, pslverr, msg_valid, spr_rvalid, mc_taken, hyp_taken, rfi_as_guest, err, t;
  int error_cnt = 0, num_checks = 0, mc_n = 0;
  doorbell_hyp_exc u_dut (.*);
  doorbell_sender u_snd (.*);
  initial forever #4 pclk = ~pclk;
  // pulses are counted so none is missed between samples
  always @(posedge pclk) if (mc_taken === 1'b1) mc_n <= mc_n + 1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic exec(input logic [3:0] op);
    @(posedge pclk);
    insn_valid <= 1'b1;
    insn_op <= op;
    insn_pc <= pc;
    @(posedge pclk);
    insn_valid <= 1'b0;
    #1;
  endtask
  task automatic spr(input logic w, input logic [2:0] s);
    @(posedge pclk);
    spr_req <= 1'b1;
    spr_wr <= w;
    spr_sel <= s;
    spr_wdata <= pc;
    @(posedge pclk);
    spr_req <= 1'b0;
    #1;
  endtask
  function automatic logic exp_trap(int m, logic [3:0] op);
    if (op == `OP_EHPRIV) return 1'b1;
    if (m == 0 || op == `OP_RFI) return 1'b0;
    if (op == `OP_TLBILX) return m == 2;
    return 1'b1;
  endfunction
  // mode 0 is hypervisor, any other mode is guest supervisor
  function automatic logic [31:0] st(int m);
    logic [31:0] v;
    v = $urandom & ~((32'h1 << `MSW_GS) | (32'h1 << `MSW_PR));
    return m ? (v | (32'h1 << `MSW_GS)) : v;
  endfunction
  // apb offset of the register that a core access of class s reaches in mode m
  function automatic logic [7:0] spr_ofs(logic [2:0] s, int m);
    case (s)
      3'h2: return m ? `OFS_GDFA : `OFS_DFA;
      3'h3: return m ? `OFS_GEPV : `OFS_EPV;
      3'h4: return `OFS_DRV;
      default: return `OFS_EPC;
    endcase
  endfunction
  initial begin
    void'($urandom(2));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFS_STAT, 0);
    chk(rd, 0);
    apb(0, 8'h3C, 0);
    chk(err, 1);
    vpr = $urandom;
    vo39 = $urandom;
    vo41 = $urandom;
    apb(1, `OFS_VPR, vpr);
    apb(1, `OFS_VO39, vo39);
    apb(1, `OFS_VO41, vo41);
    for (int m = 0; m < 3; m++) begin
      apb(1, `OFS_EPC, 32'(m == 2) << `EPC_GUEST_TLB_MGMT_DISABLE);
      for (int op = 1; op < 14; op++) begin
        ms = st(m);
        pc = $urandom;
        apb(1, `OFS_MSW, ms);
        exec(op[3:0]);
        chk(hyp_taken, exp_trap(m, op[3:0]));
        chk(rfi_as_guest, m > 0 && op == 6);
        if (exp_trap(m, op[3:0])) begin
          chk(vector_addr, {vpr[31:16], vo41[15:4], 4'h0});
          apb(0, `OFS_BSPC, 0);
          chk(rd, pc);
          apb(0, `OFS_BSST, 0);
          chk(rd, ms);
          apb(0, `OFS_MSW, 0);
          chk(rd, ms & `KEEP_HYP);
        end
      end
    end
    $display("instruction test done");
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 12; k++) begin
        ms = st(m);
        pc = $urandom;
        apb(1, `OFS_MSW, ms);
        // the target is preset to the inverse so a lost or stray core write shows
        if (k[3:1] > 3'h1) apb(1, spr_ofs(k[3:1], m), ~pc);
        spr(k[0], k[3:1]);
        t = m && k[3:1] inside {3'h1, 3'h4, 3'h5};
        chk(hyp_taken, t);
        chk(spr_rvalid, !k[0] && !t);
        if (!k[0] && !t) chk(spr_rdata, (k[3:1] > 3'h1) ? ~pc : 32'h0);
        if (k[0] && k[3:1] > 3'h1) begin
          apb(0, spr_ofs(k[3:1], m), 0);
          chk(rd, t ? ~pc : pc);
        end
      end
    end
    $display("special register test done");
    next_pc <= $urandom;
    ms = st(1) | (32'h1 << `MSW_ME);
    apb(1, `OFS_MSW, ms);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      u_snd.send(i < 4 ? 5'(i) : 5'h05 + 5'($urandom_range(26)));
    end
    apb(0, `OFS_STAT, 0);
    chk(rd, 0);
    higher_pending <= 1'b1;
    @(posedge pclk);
    u_snd.send(`MSG_GDB_MC);
    repeat (6) @(posedge pclk);
    apb(0, `OFS_STAT, 0);
    chk(rd, 1);
    chk(mc_n, 0);
    higher_pending <= 1'b0;
    for (int i = 0; i < 20 && mc_n == 0; i++) @(posedge pclk);
    chk(mc_n, 1);
    if (mc_n == 0) give_verdict();
    chk(vector_addr, {vpr[31:16], vo39[15:4], 4'h0});
    apb(0, `OFS_CSPC, 0);
    chk(rd, next_pc);
    apb(0, `OFS_CSST, 0);
    chk(rd, ms);
    apb(0, `OFS_MSW, 0);
    chk(rd, ms & `KEEP_MC);
    apb(0, `OFS_STAT, 0);
    chk(rd, 0);
    // a second message waits while guest state and then the enable are off
    u_snd.send(`MSG_GDB_MC);
    apb(1, `OFS_MSW, ms & ~(32'h1 << `MSW_ME));
    repeat (4) @(posedge pclk);
    apb(0, `OFS_STAT, 0);
    chk(rd, 1);
    chk(mc_n, 1);
    apb(1, `OFS_MSW, ms);
    for (int i = 0; i < 20 && mc_n == 1; i++) @(posedge pclk);
    chk(mc_n, 2);
    if (mc_n != 2) give_verdict();
    $display("machine check test done");
    give_verdict();
  end
endmodule // tb_guest_doorbell_mc_and_hyp_privilege_trap
